// *** design/otp_device.sv ***
/*
  Trim memory device end: live trim registers, nonvolatile array, auto-load at
  reset release and the burn engine driven by the write-go bit.
  Assumes the programmer keeps the documented sequence and waits.
*/
// Our own choices: the address map and the plain strobed port.
// Contract
// R1 - Flag one skips bank reload, zero reloads
// R2 - Six flags in bit seven of indices
// R3 - Flag A banks 00-10, flag B 11-12
// R4 - Flag C banks 13-2F plus 33-34
// R5 - Flags D, E, F bank 30-32, 35-36, 37-38
// R6 - Common high trim held at 1Fh
// R7 - Programmer blocks autoload, wakes oscillator, waits 120ms
// R8 - Programmer writes divider 17h, gamma 5Ah
// R9 - Programmer writes amplitude at 1Eh safely
// R10 - Programmer writes panel bits at 55h
// R11 - Identification bytes ignored while programming
// R12 - Programmer blocks pump clock, waits 500ms
// R13 - Programmer waits 100ms after rail applied
// R14 - Programmer sets burn mask to zero
// R15 - Write-go copies register into selected index
// R16 - Programmer waits 1ms, clears write-go between burns
// R17 - Auto-load starts at reset release unless blocked
// R18 - Programmer keeps all steps strictly ordered
module otp_device #(
  parameter int CELL_CYCLES = otp_pkg::CYC_CELL
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  otp_if.device bus,
  output logic [3:0] display_clock_divider_o,
  output logic [6:0] common_high_trim_o,
  output logic [4:0] common_amplitude_trim_o,
  output logic [4:0] panel_bits_o,
  output logic gamma_table_enable_o,
  output logic oscillator_on_o,
  output logic standby_bit_o,
  output logic pump_clock_block_o,
  output logic loading_o
);
  typedef enum logic [2:0] {
    ST_LOAD = 3'b001,
    ST_IDLE = 3'b010,
    ST_BURN = 3'b100
  } otp_state_t;

  otp_state_t state;
  logic [7:0] cells [0:63];
  logic [5:0] load_idx;
  logic [5:0] burn_idx;
  logic [7:0] burn_mask;
  logic [7:0] osc_reg;
  logic [7:0] power_reg;
  logic [7:0] amp_reg;
  logic [7:0] high_reg;
  logic [4:0] panel_reg;
  logic gamma_reg;
  logic autoload_block;
  logic pump_block;
  logic write_go;
  logic write_go_q;
  logic [15:0] cell_cnt;
  logic [7:0] burn_value;
  logic [7:0] cell_now;
  logic load_ok;

  // Index of the flag that governs a given nonvolatile location
  function automatic logic [5:0] bank_flag_idx(input logic [5:0] idx);
    if (idx <= 6'h10) begin
      bank_flag_idx = otp_pkg::IDX_FLAG_A; // [R3]
    end else if (idx <= 6'h12) begin
      bank_flag_idx = otp_pkg::IDX_FLAG_B; // [R3]
    end else if (idx <= 6'h2F || idx == 6'h33 || idx == 6'h34) begin
      bank_flag_idx = otp_pkg::IDX_FLAG_C; // [R4]
    end else if (idx <= 6'h32) begin
      bank_flag_idx = otp_pkg::IDX_FLAG_D; // [R5]
    end else if (idx <= 6'h36) begin
      bank_flag_idx = otp_pkg::IDX_FLAG_E; // [R5]
    end else begin
      bank_flag_idx = otp_pkg::IDX_FLAG_F; // [R5]
    end
  endfunction

  // Flag lives in the top data bit; a set flag skips the bank
  assign cell_now = cells[load_idx];
  assign load_ok = ~cells[bank_flag_idx(load_idx)][otp_pkg::VALID_BIT]; // [R1] [R2]

  // Live register value selected for burning
  always_comb begin
    burn_value = 8'h00;
    unique case (burn_idx)
      otp_pkg::IDX_DIVIDER: burn_value = {4'h0, osc_reg[7:4]};
      otp_pkg::IDX_AMPLITUDE: burn_value = {3'h0, amp_reg[4:0]};
      otp_pkg::IDX_COMMON_HIGH: burn_value = {1'b0, high_reg[6:0]};
      otp_pkg::IDX_PANEL: burn_value = {3'h0, panel_reg};
      otp_pkg::IDX_GAMMA: burn_value = {7'h00, gamma_reg};
      default: burn_value = 8'h00;
    endcase
  end

  // Sequencer: load after reset release, then idle, burn on write-go rise
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      state <= ST_LOAD; // [R17]
      load_idx <= 6'h00;
      cell_cnt <= 16'h0000;
      write_go_q <= 1'b0;
    end else begin
      write_go_q <= write_go;
      unique case (state)
        ST_LOAD: begin
          if (autoload_block || load_idx == otp_pkg::IDX_LAST) begin
            state <= ST_IDLE; // [R17]
          end
          load_idx <= load_idx + 6'h01;
        end
        ST_IDLE: begin
          if (write_go && !write_go_q) begin
            state <= ST_BURN; // [R15]
            cell_cnt <= 16'h0000;
          end
        end
        ST_BURN: begin
          if (cell_cnt == 16'(CELL_CYCLES - 1)) begin
            state <= ST_IDLE;
          end
          cell_cnt <= cell_cnt + 16'h0001;
        end
      endcase
    end
  end

  // Nonvolatile array: cells only gain set bits; mask bits that are 1 are spared
  always_ff @(posedge clk_sys_i) begin
    if (state == ST_BURN && cell_cnt == 16'(CELL_CYCLES - 1)) begin
      cells[burn_idx] <= cells[burn_idx] | (burn_value & ~burn_mask); // [R15]
    end
  end

  // Control bits of the programming port
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      autoload_block <= 1'b0;
      pump_block <= 1'b0;
      write_go <= 1'b0;
      burn_idx <= 6'h00;
      burn_mask <= 8'hFF;
    end else if (bus.wr) begin
      if (bus.addr == otp_pkg::ADDR_NVM_CTRL) begin
        autoload_block <= bus.wdata[otp_pkg::CTRL_AUTOLOAD_BLOCK_BIT];
        pump_block <= bus.wdata[otp_pkg::CTRL_PUMP_BLOCK_BIT];
        write_go <= bus.wdata[otp_pkg::CTRL_WRITE_GO_BIT];
      end
      if (bus.addr == otp_pkg::ADDR_NVM_INDEX) begin
        burn_idx <= bus.wdata[5:0];
      end
      if (bus.addr == otp_pkg::ADDR_NVM_MASK) begin
        burn_mask <= bus.wdata;
      end
    end
  end

  // Live trim registers: software write, else auto-load from an unflagged bank
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      osc_reg <= otp_pkg::RST_OSC_CTRL;
      power_reg <= otp_pkg::RST_POWER_CTRL;
      amp_reg <= otp_pkg::RST_AMPLITUDE;
      high_reg <= otp_pkg::RST_COMMON_HIGH;
      panel_reg <= 5'h00;
      gamma_reg <= 1'b0;
    end else if (bus.wr) begin
      unique case (bus.addr)
        otp_pkg::ADDR_OSC_CTRL: osc_reg <= bus.wdata;
        otp_pkg::ADDR_POWER_CTRL: power_reg <= bus.wdata;
        otp_pkg::ADDR_AMPLITUDE: amp_reg <= {3'h0, bus.wdata[4:0]};
        otp_pkg::ADDR_COMMON_HIGH: high_reg <= {1'b0, bus.wdata[6:0]}; // [R6]
        otp_pkg::ADDR_PANEL_CTRL: panel_reg <= bus.wdata[4:0];
        otp_pkg::ADDR_IP_CTRL: gamma_reg <= bus.wdata[otp_pkg::GAMMA_BIT];
        default: ;
      endcase
    end else if (state == ST_LOAD && !autoload_block && load_ok) begin
      // Identification bytes are never reloaded nor burned here [R11]
      unique case (load_idx)
        otp_pkg::IDX_DIVIDER: osc_reg <= {cell_now[3:0], osc_reg[3:0]};
        otp_pkg::IDX_AMPLITUDE: amp_reg <= {3'h0, cell_now[4:0]};
        otp_pkg::IDX_COMMON_HIGH: high_reg <= {1'b0, cell_now[6:0]};
        otp_pkg::IDX_PANEL: panel_reg <= cell_now[4:0];
        otp_pkg::IDX_GAMMA: gamma_reg <= cell_now[0];
        default: ;
      endcase
    end
  end

  // Read data one cycle after the strobe
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      bus.rdata <= 8'h00;
    end else if (bus.rd) begin
      unique case (bus.addr)
        otp_pkg::ADDR_OSC_CTRL: bus.rdata <= osc_reg;
        otp_pkg::ADDR_POWER_CTRL: bus.rdata <= power_reg;
        otp_pkg::ADDR_AMPLITUDE: bus.rdata <= amp_reg;
        otp_pkg::ADDR_COMMON_HIGH: bus.rdata <= high_reg;
        otp_pkg::ADDR_PANEL_CTRL: bus.rdata <= {3'h0, panel_reg};
        otp_pkg::ADDR_IP_CTRL: bus.rdata <= {7'h00, gamma_reg};
        otp_pkg::ADDR_NVM_CTRL: bus.rdata <= {5'h00, write_go, pump_block, autoload_block};
        otp_pkg::ADDR_NVM_INDEX: bus.rdata <= {2'h0, burn_idx};
        otp_pkg::ADDR_NVM_MASK: bus.rdata <= burn_mask;
        default: bus.rdata <= 8'h00;
      endcase
    end
  end

  // Status and live trim outputs
  assign bus.busy = (state != ST_IDLE);
  assign loading_o = (state == ST_LOAD);
  assign display_clock_divider_o = osc_reg[7:4];
  assign oscillator_on_o = osc_reg[otp_pkg::OSC_ON_BIT];
  assign standby_bit_o = power_reg[otp_pkg::STANDBY_BIT];
  assign common_high_trim_o = high_reg[6:0];
  assign common_amplitude_trim_o = amp_reg[4:0];
  assign panel_bits_o = panel_reg;
  assign gamma_table_enable_o = gamma_reg;
  assign pump_clock_block_o = pump_block;
endmodule

// *** design/otp_pkg.sv ***
/*
  Shared constants for the trim memory device end and its programmer end.
  Assumes a single 20 MHz system clock and a synchronous active-low reset.
*/
package otp_pkg;
  localparam int CLK_HZ = 20000000;
  localparam int MS_PER_S = 1000;
  // Register-content addresses used by the programming sequence
  localparam logic [7:0] ADDR_OSC_CTRL = 8'h17;
  localparam logic [7:0] ADDR_POWER_CTRL = 8'h19;
  localparam logic [7:0] ADDR_AMPLITUDE = 8'h1E;
  localparam logic [7:0] ADDR_COMMON_HIGH = 8'h1F;
  localparam logic [7:0] ADDR_PANEL_CTRL = 8'h55;
  localparam logic [7:0] ADDR_IP_CTRL = 8'h5A;
  localparam logic [7:0] ADDR_NVM_CTRL = 8'hE0;
  localparam logic [7:0] ADDR_NVM_INDEX = 8'hE1;
  localparam logic [7:0] ADDR_NVM_MASK = 8'hE2;
  // Bit positions inside the control registers and the bank flag bytes
  localparam int OSC_ON_BIT = 0;
  localparam int STANDBY_BIT = 0;
  localparam int GAMMA_BIT = 0;
  localparam int CTRL_AUTOLOAD_BLOCK_BIT = 0;
  localparam int CTRL_PUMP_BLOCK_BIT = 1;
  localparam int CTRL_WRITE_GO_BIT = 2;
  localparam int VALID_BIT = 7;
  // Reset values
  localparam logic [7:0] RST_OSC_CTRL = 8'hF0;
  localparam logic [7:0] RST_POWER_CTRL = 8'h09;
  localparam logic [7:0] RST_AMPLITUDE = 8'h10;
  localparam logic [7:0] RST_COMMON_HIGH = 8'h55;
  // Nonvolatile indices
  localparam logic [5:0] IDX_DIVIDER = 6'h10;
  localparam logic [5:0] IDX_AMPLITUDE = 6'h11;
  localparam logic [5:0] IDX_COMMON_HIGH = 6'h12;
  localparam logic [5:0] IDX_PANEL = 6'h13;
  localparam logic [5:0] IDX_GAMMA = 6'h33;
  localparam logic [5:0] IDX_LAST = 6'h38;
  localparam logic [5:0] IDX_FLAG_A = 6'h0F;
  localparam logic [5:0] IDX_FLAG_B = 6'h12;
  localparam logic [5:0] IDX_FLAG_C = 6'h33;
  localparam logic [5:0] IDX_FLAG_D = 6'h31;
  localparam logic [5:0] IDX_FLAG_E = 6'h36;
  localparam logic [5:0] IDX_FLAG_F = 6'h38;
  localparam logic [7:0] MASK_ALL_BITS = 8'h00;
  // Waits, in milliseconds, then lengths in clock cycles
  localparam int T_OSC_MS = 120;
  localparam int T_PUMP_MS = 500;
  localparam int T_RAIL_MS = 100;
  localparam int T_BURN_MS = 1;
  localparam int CYC_OSC = T_OSC_MS * (CLK_HZ / MS_PER_S);
  localparam int CYC_PUMP = T_PUMP_MS * (CLK_HZ / MS_PER_S);
  localparam int CYC_RAIL = T_RAIL_MS * (CLK_HZ / MS_PER_S);
  localparam int CYC_BURN = T_BURN_MS * (CLK_HZ / MS_PER_S);
  localparam int CYC_CELL = 16;
endpackage

// *** design/otp_if.sv ***
/*
  Register-content port between the programmer and the trim device.
  Assumes both ends share clk_sys_i; one access per cycle, read data next cycle.
*/
interface otp_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic busy;
  modport device (input addr, input wdata, input wr, input rd, output rdata, output busy);
  modport host (output addr, output wdata, output wr, output rd, input rdata, input busy);
endinterface

// *** design/otp_host.sv ***
/*
  Programmer end: walks the burn sequence with its waits over the port.
  Assumes the user pulses start_i with trim values held stable; rail_ready_i
  is a pin from outside and is synchronised here.
*/
module otp_host #(
  parameter int WAIT_OSC = otp_pkg::CYC_OSC,
  parameter int WAIT_PUMP = otp_pkg::CYC_PUMP,
  parameter int WAIT_RAIL = otp_pkg::CYC_RAIL,
  parameter int WAIT_BURN = otp_pkg::CYC_BURN
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  otp_if.host bus,
  input wire logic start_i,
  input wire logic [3:0] display_clock_divider_i,
  input wire logic gamma_table_enable_i,
  input wire logic [6:0] common_high_trim_i,
  input wire logic [4:0] common_amplitude_trim_i,
  input wire logic [4:0] panel_bits_i,
  input wire logic rail_ready_i,
  output logic rail_request_o,
  output logic busy_o,
  output logic done_o
);
  typedef enum logic [3:0] {
    HS_IDLE = 4'b0001,
    HS_WRITE = 4'b0010,
    HS_WAIT = 4'b0100,
    HS_RAIL = 4'b1000
  } host_state_t;

  host_state_t state;
  logic [4:0] step;
  logic [31:0] wait_cnt;
  logic [2:0] rail_sync;
  logic rail_ok;

  // Three-stage pin synchroniser; second and third must agree
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rail_sync <= 3'b000;
      rail_ok <= 1'b0;
    end else begin
      rail_sync <= {rail_sync[1:0], rail_ready_i};
      if (rail_sync[2] == rail_sync[1]) begin
        rail_ok <= rail_sync[2];
      end
    end
  end

  // Ordered steps: writes, some followed by a wait, in fixed order, never skipped [R18]
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      state <= HS_IDLE;
      step <= 5'h00;
      wait_cnt <= 32'h0000_0000;
      bus.addr <= 8'h00;
      bus.wdata <= 8'h00;
      bus.wr <= 1'b0;
      rail_request_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      bus.wr <= 1'b0;
      done_o <= 1'b0;
      unique case (state)
        HS_IDLE: begin
          if (start_i) begin
            state <= HS_WRITE;
            step <= 5'h00;
          end
        end
        HS_WRITE: begin
          bus.wr <= 1'b1;
          state <= HS_WRITE;
          step <= step + 5'h01;
          unique case (step)
            5'h00: {bus.addr, bus.wdata} <= {otp_pkg::ADDR_NVM_CTRL, 8'h01}; // [R7]
            5'h01: {bus.addr, bus.wdata} <= {otp_pkg::ADDR_OSC_CTRL, 8'h01}; // [R7]
            5'h02: begin
              {bus.addr, bus.wdata} <= {otp_pkg::ADDR_POWER_CTRL, 8'h08}; // [R7]
              wait_cnt <= 32'(WAIT_OSC);
              state <= HS_WAIT;
            end
            5'h03: {bus.addr, bus.wdata} <= {otp_pkg::ADDR_OSC_CTRL,
                                            display_clock_divider_i, 4'h1}; // [R8]
            5'h04: {bus.addr, bus.wdata} <= {otp_pkg::ADDR_IP_CTRL,
                                            7'h00, gamma_table_enable_i}; // [R8]
            5'h05: {bus.addr, bus.wdata} <= {otp_pkg::ADDR_COMMON_HIGH,
                                            1'b0, common_high_trim_i};
            5'h06: {bus.addr, bus.wdata} <= {otp_pkg::ADDR_AMPLITUDE,
                                            3'h0, common_amplitude_trim_i}; // [R9]
            5'h07: {bus.addr, bus.wdata} <= {otp_pkg::ADDR_PANEL_CTRL,
                                            3'h0, panel_bits_i}; // [R10]
            5'h08: begin
              {bus.addr, bus.wdata} <= {otp_pkg::ADDR_NVM_CTRL, 8'h03}; // [R12]
              wait_cnt <= 32'(WAIT_PUMP);
              state <= HS_WAIT;
            end
            5'h09: begin
              bus.wr <= 1'b0;
              rail_request_o <= 1'b1;
              state <= HS_RAIL;
            end
            5'h0A: {bus.addr, bus.wdata} <= {otp_pkg::ADDR_NVM_MASK,
                                            otp_pkg::MASK_ALL_BITS}; // [R14]
            5'h0B, 5'h0E, 5'h11, 5'h14, 5'h17: begin
              bus.addr <= otp_pkg::ADDR_NVM_INDEX;
              unique case (step)
                5'h0B: bus.wdata <= {2'h0, otp_pkg::IDX_DIVIDER};
                5'h0E: bus.wdata <= {2'h0, otp_pkg::IDX_AMPLITUDE};
                5'h11: bus.wdata <= {2'h0, otp_pkg::IDX_COMMON_HIGH};
                5'h14: bus.wdata <= {2'h0, otp_pkg::IDX_PANEL};
                default: bus.wdata <= {2'h0, otp_pkg::IDX_GAMMA};
              endcase
            end
            5'h0C, 5'h0F, 5'h12, 5'h15, 5'h18: begin
              {bus.addr, bus.wdata} <= {otp_pkg::ADDR_NVM_CTRL, 8'h07};
              wait_cnt <= 32'(WAIT_BURN); // [R16]
              state <= HS_WAIT;
            end
            5'h0D, 5'h10, 5'h13, 5'h16, 5'h19: begin
              {bus.addr, bus.wdata} <= {otp_pkg::ADDR_NVM_CTRL, 8'h03}; // [R16]
            end
            default: begin
              bus.wr <= 1'b0;
              rail_request_o <= 1'b0;
              done_o <= 1'b1;
              state <= HS_IDLE;
            end
          endcase
        end
        HS_WAIT: begin
          if (wait_cnt <= 32'h0000_0001) begin
            state <= HS_WRITE;
          end
          wait_cnt <= wait_cnt - 32'h0000_0001;
        end
        HS_RAIL: begin
          if (rail_ok) begin
            wait_cnt <= 32'(WAIT_RAIL); // [R13]
            state <= HS_WAIT;
          end
        end
      endcase
    end
  end

  assign bus.rd = 1'b0;
  assign busy_o = (state != HS_IDLE);
endmodule

// *** verification/otp_port_checker.sv ***
/* Concurrent checks on the port between the programmer end and the trim device.
   Assumes one clock, synchronous active-low reset, signals of the joining port. */
module otp_port_checker #(
  parameter int WAIT_OSC = 20,
  parameter int WAIT_PUMP = 20,
  parameter int WAIT_RAIL = 20,
  parameter int WAIT_BURN = 20,
  parameter int CELL_CYCLES = 4
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic busy
);
  logic [7:0] last_addr;
  logic [7:0] last_data;
  logic [15:0] gap;
  logic [7:0] burn_cnt;
  logic burning;
  logic go;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // Write-go accepted by an idle device
  assign go = wr && addr == otp_pkg::ADDR_NVM_CTRL && wdata[otp_pkg::CTRL_WRITE_GO_BIT] && !busy;
  // Last write and cycles since it
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      last_addr <= 8'h00;
      last_data <= 8'h00;
      gap <= 16'h0000;
    end else if (wr) begin
      last_addr <= addr;
      last_data <= wdata;
      gap <= 16'h0001;
    end else if (gap != 16'hFFFF) begin
      gap <= gap + 16'h0001;
    end
  end
  // Busy cycles of the burn in flight; busy rises two cycles after the write
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      burning <= 1'b0;
      burn_cnt <= 8'h00;
    end else if (go) begin
      burning <= 1'b1;
      burn_cnt <= 8'h00;
    end else if (burning && busy) begin
      burn_cnt <= burn_cnt + 8'h01;
    end else if (burning && burn_cnt != 8'h00) begin
      burning <= 1'b0;
    end
  end
  sequence s_block;
    wr && addr == otp_pkg::ADDR_NVM_CTRL && wdata == 8'h01;
  endsequence
  sequence s_wake;
    (wr && addr == otp_pkg::ADDR_OSC_CTRL && wdata == 8'h01)
      ##1 (wr && addr == otp_pkg::ADDR_POWER_CTRL && wdata == 8'h08);
  endsequence
  a_prep_order: assert property (s_block |=> s_wake)
    else $error("oscillator and standby writes do not follow the load block");
  a_osc_wait: assert property (wr && last_addr == otp_pkg::ADDR_POWER_CTRL |-> gap >= WAIT_OSC)
    else $error("trim write before the oscillator wait ended");
  a_pump_rail_wait: assert property (wr && addr == otp_pkg::ADDR_NVM_MASK |->
    last_addr == otp_pkg::ADDR_NVM_CTRL && last_data == 8'h03 && gap >= WAIT_PUMP + WAIT_RAIL)
    else $error("burn setup before pump and rail waits ended");
  a_mask_zero: assert property (wr && addr == otp_pkg::ADDR_NVM_MASK |-> wdata == 8'h00)
    else $error("burn mask not zero");
  a_burn_release: assert property (wr && last_addr == otp_pkg::ADDR_NVM_CTRL &&
    last_data == 8'h07 |-> addr == otp_pkg::ADDR_NVM_CTRL && wdata == 8'h03 && gap >= WAIT_BURN)
    else $error("write-go not cleared after the burn wait");
  a_go_after_index: assert property (wr && addr == otp_pkg::ADDR_NVM_CTRL &&
    wdata == 8'h07 |-> last_addr == otp_pkg::ADDR_NVM_INDEX)
    else $error("write-go without a parameter index");
  a_go_busy: assert property (go |=> !busy ##1 busy)
    else $error("burn did not start after write-go");
  a_burn_length: assert property (burning && !busy && $past(busy) |-> burn_cnt == CELL_CYCLES)
    else $error("burn busy length wrong");
  a_load_start: assert property ($rose(rst_n_i) |-> busy)
    else $error("auto-load not running at reset release");
  a_load_bound: assert property ($rose(rst_n_i) |-> ##[1:60] !busy)
    else $error("auto-load did not finish");
  a_high_field: assert property (wr && addr == otp_pkg::ADDR_COMMON_HIGH |-> !wdata[7])
    else $error("common high trim wider than seven bits");
endmodule

// *** verification/tb_otp_trim_programming.sv ***
/* Testbench: host burns trims into one device; a second device is driven here.
   Assumes the design package, port interface and both design ends compiled first. */
module tb_otp_trim_programming;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int W = 20;
  localparam int CELL = 4;
  typedef struct packed {
    logic [3:0] div;
    logic gam;
    logic [6:0] high;
    logic [4:0] amp;
    logic [4:0] pan;
    logic [3:0] dly;
  } otp_row_t;
  otp_row_t rows[3] = '{'{4'hF, 1'b1, 7'h7F, 5'h1F, 5'h1F, 4'h0},
    '{4'h0, 1'b0, 7'h00, 5'h00, 5'h00, 4'h9}, '{4'hA, 1'b1, 7'h2A, 5'h15, 5'h0A, 4'h3}};
  logic [15:0] regs[6] = '{{otp_pkg::ADDR_OSC_CTRL, otp_pkg::RST_OSC_CTRL},
    {otp_pkg::ADDR_POWER_CTRL, otp_pkg::RST_POWER_CTRL},
    {otp_pkg::ADDR_AMPLITUDE, otp_pkg::RST_AMPLITUDE},
    {otp_pkg::ADDR_COMMON_HIGH, otp_pkg::RST_COMMON_HIGH}, {otp_pkg::ADDR_NVM_MASK, 8'hFF},
    {8'h40, 8'h00}};
  logic clk_sys_i = 1'b0;
  logic rst_n_i;
  logic rst2_n;
  logic start;
  logic rail_ready;
  logic rail_req;
  logic done;
  logic [3:0] dv;
  logic [6:0] hi;
  logic [6:0] hi2;
  logic [4:0] am;
  logic [4:0] pa;
  logic ga;
  logic on;
  logic sb;
  logic pb;
  logic ld2;
  logic ld1;
  logic hb;
  logic [7:0] v;
  otp_row_t r;
  int rail_cnt;
  int n;
  int num_errors;
  int n_compared;
  otp_if bus1();
  otp_if bus2();
  otp_host #(.WAIT_OSC(W), .WAIT_PUMP(W), .WAIT_RAIL(W), .WAIT_BURN(W)) otp_host_inst (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .bus(bus1.host), .start_i(start),
    .display_clock_divider_i(r.div), .gamma_table_enable_i(r.gam), .common_high_trim_i(r.high),
    .common_amplitude_trim_i(r.amp), .panel_bits_i(r.pan), .rail_ready_i(rail_ready),
    .rail_request_o(rail_req), .busy_o(hb), .done_o(done));
  otp_device #(.CELL_CYCLES(CELL)) otp_device_inst (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .bus(bus1.device), .display_clock_divider_o(dv),
    .common_high_trim_o(hi), .common_amplitude_trim_o(am), .panel_bits_o(pa),
    .gamma_table_enable_o(ga), .oscillator_on_o(on), .standby_bit_o(sb),
    .pump_clock_block_o(pb), .loading_o(ld1));
  otp_device #(.CELL_CYCLES(CELL)) otp_device_inst2 (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst2_n), .bus(bus2.device), .display_clock_divider_o(),
    .common_high_trim_o(hi2), .common_amplitude_trim_o(), .panel_bits_o(),
    .gamma_table_enable_o(), .oscillator_on_o(), .standby_bit_o(),
    .pump_clock_block_o(), .loading_o(ld2));
  otp_port_checker #(.WAIT_OSC(W), .WAIT_PUMP(W), .WAIT_RAIL(W), .WAIT_BURN(W),
    .CELL_CYCLES(CELL)) otp_port_checker_inst (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr(bus1.addr), .wdata(bus1.wdata),
    .wr(bus1.wr), .rd(bus1.rd), .rdata(bus1.rdata), .busy(bus1.busy));
  // System clock, 50 ns period
  always #25 clk_sys_i = ~clk_sys_i;
  // External rail settles some cycles after it is requested
  always @(posedge clk_sys_i) begin
    rail_cnt <= rail_req ? rail_cnt + 1 : 0;
    rail_ready <= rail_req && rail_cnt >= int'(r.dly);
  end
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr2(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    bus2.addr <= a;
    bus2.wdata <= d;
    bus2.wr <= 1'b1;
    @(posedge clk_sys_i);
    bus2.wr <= 1'b0;
  endtask
  task automatic rd2(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    bus2.addr <= a;
    bus2.rd <= 1'b1;
    @(posedge clk_sys_i);
    bus2.rd <= 1'b0;
    #1 d = bus2.rdata;
  endtask
  task automatic finish_test();
    $display("Comparisons %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    num_errors++;
    finish_test();
  end
  // Main sequence
  initial begin
    {rst_n_i, rst2_n, start, rail_cnt, rail_ready, num_errors, n_compared} = '0;
    r = rows[0];
    {bus2.addr, bus2.wdata, bus2.wr, bus2.rd} = '0;
    repeat (8) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    rst2_n <= 1'b1;
    #1 check("load at release", 8'h03, {6'h00, ld1, ld2});
    wr2(otp_pkg::ADDR_NVM_CTRL, 8'h01);
    repeat (2) @(posedge clk_sys_i);
    #1 check("load blocked", 8'h00, {7'h00, ld2});
    foreach (regs[i]) begin
      rd2(regs[i][15:8], v);
      check("reset read", regs[i][7:0], v);
    end
    wr2(otp_pkg::ADDR_COMMON_HIGH, 8'h2A);
    rd2(otp_pkg::ADDR_COMMON_HIGH, v);
    check("high trim read", 8'h2A, v);
    check("high trim out", 8'h2A, {1'b0, hi2});
    wr2(otp_pkg::ADDR_NVM_INDEX, {2'b00, otp_pkg::IDX_COMMON_HIGH});
    wr2(otp_pkg::ADDR_NVM_MASK, otp_pkg::MASK_ALL_BITS);
    wr2(otp_pkg::ADDR_NVM_CTRL, 8'h07);
    @(posedge clk_sys_i);
    #1 check("burn start", 8'h01, {7'h00, bus2.busy});
    n = 0;
    while (bus2.busy === 1'b1 && n < 50) begin
      @(posedge clk_sys_i);
      #1 n++;
    end
    check("burn length", CELL[7:0], n[7:0]);
    // Second reset: write-go during the load walk is ignored
    @(posedge clk_sys_i);
    rst2_n <= 1'b0;
    repeat (8) @(posedge clk_sys_i);
    rst2_n <= 1'b1;
    wr2(otp_pkg::ADDR_NVM_CTRL, 8'h04);
    repeat (40) @(posedge clk_sys_i);
    #1 check("walk running", 8'h01, {7'h00, bus2.busy});
    repeat (17) @(posedge clk_sys_i);
    #1 check("go refused", 8'h00, {7'h00, bus2.busy});
    foreach (rows[i]) begin
      @(posedge clk_sys_i);
      r <= rows[i];
      start <= 1'b1;
      @(posedge clk_sys_i);
      start <= 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 3000) begin
        @(posedge clk_sys_i);
        #1 n++;
      end
      check("done", 8'h01, {7'h00, done});
      check("host idle", 8'h00, {7'h00, hb});
      check("divider", {4'h0, r.div}, {4'h0, dv});
      check("gamma", {7'h00, r.gam}, {7'h00, ga});
      check("high trim", {1'b0, r.high}, {1'b0, hi});
      check("amplitude", {3'h0, r.amp}, {3'h0, am});
      check("panel", {3'h0, r.pan}, {3'h0, pa});
      check("osc and standby", 8'h02, {6'h00, on, sb});
      check("pump block", 8'h01, {7'h00, pb});
    end
    finish_test();
  end
endmodule
